// ===== hdl/csrbit_defs.vh
/*
 * csrbit_defs.vh: reset values and field layout for the register bit access library.
 * Assumes inclusion by csrbit_policy_bank.v only; defines only.
 */
`ifndef CSRBIT_DEFS_VH
`define CSRBIT_DEFS_VH

// ----------------------------------------------------------------------------
// data width and bit positions within the 16-bit status word
// ----------------------------------------------------------------------------
`define CSRBIT_WIDTH 16
`define CSRBIT_POS_RO 0
`define CSRBIT_POS_SOR 1
`define CSRBIT_POS_COR 2
`define CSRBIT_POS_WO 3
`define CSRBIT_POS_W1C 4
`define CSRBIT_POS_WAC 5
`define CSRBIT_POS_LL 6
`define CSRBIT_POS_LH 7
`define CSRBIT_POS_SC 8
`define CSRBIT_POS_SS 9
`define CSRBIT_POS_ROLH 10
`define CSRBIT_POS_STICKY 11
`define CSRBIT_POS_KLR 12
`define CSRBIT_POS_KSR 13

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CSRBIT_RST_SOR 1'b0
`define CSRBIT_RST_WO 1'b0
`define CSRBIT_RST_LL 1'b1
`define CSRBIT_RST_SS 1'b1
`define CSRBIT_RST_KEEP 1'b0
`define CSRBIT_RST_WORD 16'h0000

`endif

// ===== hdl/csrbit_policy_bank.v
/*
 * csrbit_policy_bank.v: one register word with one bit of each access policy.
 * Assumes a host path that gives one-cycle read and write strobes, and condition
 * inputs synchronous to clk. A read returns data one cycle after the strobe.
 * Lite and soft reset are level inputs in the clk domain; they never clear the
 * hardware-owned status bits, only the software-written state named below.
 */
`include "csrbit_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module csrbit_policy_bank
(
   input wire clk,
   input wire reset_n,
   input wire liteReset,
   input wire softReset,
   input wire regRead,
   input wire regWrite,
   input wire [15:0] writeData,
   input wire roValue,
   input wire corSet,
   input wire w1cSet,
   input wire wacSet,
   input wire latchLowCond,
   input wire latchHighCond,
   input wire selfClearDone,
   input wire selfSetDone,
   input wire statusCond,
   input wire stickyCond,
   output reg [15:0] readData,
   output wire readValid,
   output wire woValue,
   output wire selfClearBit,
   output wire selfSetBit,
   output wire keepOnLiteReset,
   output wire keepOnSoftReset
);

   // ----------------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------------
   reg setOnRead_q;
   reg clearOnRead_q;
   reg writeOnly_q;
   reg w1c_q;
   reg writeAnyClear_q;
   reg latchLowBit_q;
   reg latchHighBit_q;
   reg selfClear_q;
   reg selfSet_q;
   reg statusLatched_q;
   reg statusRead_q;
   reg sticky_q;
   reg keepLite_q;
   reg keepSoft_q;
   reg readValid_q;
   reg [15:0] readWord;

   // one accessor keeps every write decode tied to one bit position
   function wdBit;
      input [15:0] data;
      input integer pos;
      begin
         wdBit = data[pos];
      end
   endfunction

   // ----------------------------------------------------------------------------
   // read word: captured values are those before the read side effects
   // ----------------------------------------------------------------------------
   always @*
   begin
      readWord = `CSRBIT_RST_WORD;
      readWord[`CSRBIT_POS_RO] = roValue;
      readWord[`CSRBIT_POS_SOR] = setOnRead_q;
      readWord[`CSRBIT_POS_COR] = clearOnRead_q;
      // write-only reads zero so no stored command leaks back out
      readWord[`CSRBIT_POS_WO] = 1'b0;
      readWord[`CSRBIT_POS_W1C] = w1c_q;
      readWord[`CSRBIT_POS_WAC] = writeAnyClear_q;
      readWord[`CSRBIT_POS_LL] = latchLowBit_q;
      readWord[`CSRBIT_POS_LH] = latchHighBit_q;
      readWord[`CSRBIT_POS_SC] = selfClear_q;
      readWord[`CSRBIT_POS_SS] = selfSet_q;
      readWord[`CSRBIT_POS_ROLH] = statusLatched_q;
      readWord[`CSRBIT_POS_STICKY] = sticky_q;
      readWord[`CSRBIT_POS_KLR] = keepLite_q;
      readWord[`CSRBIT_POS_KSR] = keepSoft_q;
   end

   // ----------------------------------------------------------------------------
   // read port: registered answer one cycle after the strobe
   // ----------------------------------------------------------------------------
   // the captured word is the one before this edge's side effects take hold
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         readValid_q <= 1'b0;
         readData <= `CSRBIT_RST_WORD;
      end
      else
      begin
         readValid_q <= regRead;
         if (regRead)
         begin
            readData <= readWord;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // bit policies; a simultaneous read and write is treated as both, except set-on-read, where the read wins
   // ----------------------------------------------------------------------------
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         setOnRead_q <= `CSRBIT_RST_SOR;
         clearOnRead_q <= 1'b0;
         writeOnly_q <= `CSRBIT_RST_WO;
         w1c_q <= 1'b0;
         writeAnyClear_q <= 1'b0;
         latchLowBit_q <= `CSRBIT_RST_LL;
         latchHighBit_q <= 1'b0;
         selfClear_q <= 1'b0;
         selfSet_q <= `CSRBIT_RST_SS;
         statusLatched_q <= 1'b0;
         statusRead_q <= 1'b0;
         sticky_q <= 1'b0;
      end
      else
      begin
         // set-on-read: software writes may clear it, the next read sets it again
         if (regRead)
         begin
            setOnRead_q <= 1'b1;
         end
         else if (regWrite)
         begin
            setOnRead_q <= wdBit(writeData, `CSRBIT_POS_SOR);
         end
         // clear-on-read: an event in the read cycle survives the clear
         if (corSet)
         begin
            clearOnRead_q <= 1'b1;
         end
         else if (regRead)
         begin
            clearOnRead_q <= 1'b0;
         end
         if (regWrite)
         begin
            writeOnly_q <= wdBit(writeData, `CSRBIT_POS_WO);
         end
         if (w1cSet)
         begin
            w1c_q <= 1'b1;
         end
         else if (regWrite && wdBit(writeData, `CSRBIT_POS_W1C))
         begin
            w1c_q <= 1'b0;
         end
         if (wacSet)
         begin
            writeAnyClear_q <= 1'b1;
         end
         else if (regWrite)
         begin
            writeAnyClear_q <= 1'b0;
         end
         // latch-low rearms to one on read unless the low condition persists
         if (latchLowCond)
         begin
            latchLowBit_q <= 1'b0;
         end
         else if (regRead)
         begin
            latchLowBit_q <= 1'b1;
         end
         if (latchHighCond)
         begin
            latchHighBit_q <= 1'b1;
         end
         else if (regRead)
         begin
            latchHighBit_q <= 1'b0;
         end
         // self-clear: software starts it, the hardware done strobe ends it
         if (regWrite && wdBit(writeData, `CSRBIT_POS_SC))
         begin
            selfClear_q <= 1'b1;
         end
         else if (selfClearDone)
         begin
            selfClear_q <= 1'b0;
         end
         if (regWrite && !wdBit(writeData, `CSRBIT_POS_SS))
         begin
            selfSet_q <= 1'b0;
         end
         else if (selfSetDone)
         begin
            selfSet_q <= 1'b1;
         end
         // latched status: a read arms the fall, which then waits for the condition to go
         // without the armed flag a condition dropping after the read would leave the bit high
         if (statusCond)
         begin
            statusLatched_q <= 1'b1;
         end
         else if (regRead || statusRead_q)
         begin
            statusLatched_q <= 1'b0;
         end
         // armed only while high; a fresh rise after the fall needs a fresh read
         if (!statusLatched_q)
         begin
            statusRead_q <= 1'b0;
         end
         else if (regRead)
         begin
            statusRead_q <= 1'b1;
         end

         if (stickyCond)
         begin
            sticky_q <= 1'b1;
         end
         else if (regWrite && !wdBit(writeData, `CSRBIT_POS_STICKY))
         begin
            sticky_q <= 1'b0;
         end
         // lite and soft reset return the non-retained software state only
         if (liteReset || softReset)
         begin
            setOnRead_q <= `CSRBIT_RST_SOR;
            writeOnly_q <= `CSRBIT_RST_WO;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // retained bits: each survives its own reset kind, the other kind clears it
   // ----------------------------------------------------------------------------
   // a write in the same cycle as the clearing reset loses to that reset
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         keepLite_q <= `CSRBIT_RST_KEEP;
         keepSoft_q <= `CSRBIT_RST_KEEP;
      end
      else
      begin
         // software owns both bits between resets
         if (regWrite)
         begin
            keepLite_q <= wdBit(writeData, `CSRBIT_POS_KLR);
            keepSoft_q <= wdBit(writeData, `CSRBIT_POS_KSR);
         end
         if (softReset)
         begin
            keepLite_q <= `CSRBIT_RST_KEEP;
         end
         if (liteReset)
         begin
            keepSoft_q <= `CSRBIT_RST_KEEP;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------------
   assign readValid = readValid_q;
   assign woValue = writeOnly_q;
   assign selfClearBit = selfClear_q;
   assign selfSetBit = selfSet_q;
   assign keepOnLiteReset = keepLite_q;
   assign keepOnSoftReset = keepSoft_q;

endmodule // csrbit_policy_bank
`default_nettype wire

// ===== verif/csrbit_policy_bank_checker.sv
/* csrbit_policy_bank_checker: port assertions for the bit access policy bank.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module csrbit_policy_bank_checker
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic liteReset,
   input wire logic softReset,
   input wire logic regRead,
   input wire logic regWrite,
   input wire logic roValue,
   input wire logic corSet,
   input wire logic selfClearDone,
   input wire logic selfSetDone,
   input wire logic [15:0] readData,
   input wire logic readValid,
   input wire logic selfClearBit,
   input wire logic selfSetBit,
   input wire logic keepOnLiteReset,
   input wire logic keepOnSoftReset
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   sequence quietRead;
      regRead && !regWrite && !liteReset && !softReset && !corSet;
   endsequence
   // second read must see what the first read left behind
   sequence twoReads;
      quietRead ##1 quietRead;
   endsequence
   ro_live_a: assert property (regRead |=> readData[0] == $past(roValue))
      else $error("read-only bit not live");
   sor_set_a: assert property (twoReads |=> readData[1])
      else $error("set-on-read bit not set");
   cor_clear_a: assert property (twoReads |=> !readData[2])
      else $error("clear-on-read bit not cleared");
   sc_done_a: assert property (selfClearDone && !regWrite |=> !selfClearBit)
      else $error("self-clear bit stuck");
   ss_done_a: assert property (selfSetDone |=> selfSetBit)
      else $error("self-set bit stuck");
   klr_keep_a: assert property (liteReset && !softReset && !regWrite |=> $stable(keepOnLiteReset))
      else $error("lite reset changed retained bit");
   ksr_keep_a: assert property (softReset && !liteReset && !regWrite |=> $stable(keepOnSoftReset))
      else $error("soft reset changed retained bit");
   rst_vals_a: assert property (disable iff (1'b0) !reset_n |=> readData == 16'h0000 && !readValid
      && selfSetBit && !selfClearBit && !keepOnLiteReset && !keepOnSoftReset)
      else $error("reset values wrong");
endmodule // csrbit_policy_bank_checker

bind csrbit_policy_bank csrbit_policy_bank_checker i_csrbit_policy_bank_checker (.clk, .reset_n, .liteReset,
   .softReset, .regRead, .regWrite, .roValue, .corSet, .selfClearDone, .selfSetDone, .readData, .readValid,
   .selfClearBit, .selfSetBit, .keepOnLiteReset, .keepOnSoftReset);
`default_nettype wire

// ===== verif/csrbit_policy_bank_tb_top.sv
/* csrbit_policy_bank_tb_top: directed scenarios for the bit access policy bank.
   Assumes a read answer one cycle after the strobe; inputs move at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module csrbit_policy_bank_tb_top;
   logic clk = 1'b0, reset_n = 1'b0, liteReset = 1'b0, softReset = 1'b0, regRead = 1'b0, regWrite = 1'b0;
   logic roValue = 1'b0, corSet = 1'b0, w1cSet = 1'b0, wacSet = 1'b0, latchLowCond = 1'b0;
   logic latchHighCond = 1'b0, selfClearDone = 1'b0, selfSetDone = 1'b0, statusCond = 1'b0, stickyCond = 1'b0;
   logic [15:0] writeData = 16'h0000;
   wire [15:0] readData;
   wire readValid, woValue, selfClearBit, selfSetBit, keepOnLiteReset, keepOnSoftReset;
   int miscompares = 0;
   int checkCount = 0;
   csrbit_policy_bank i_csrbit_policy_bank (.clk, .reset_n, .liteReset, .softReset, .regRead, .regWrite,
      .writeData, .roValue, .corSet, .w1cSet, .wacSet, .latchLowCond, .latchHighCond, .selfClearDone,
      .selfSetDone, .statusCond, .stickyCond, .readData, .readValid, .woValue, .selfClearBit, .selfSetBit,
      .keepOnLiteReset, .keepOnSoftReset);
   initial forever #4 clk = ~clk;
   task chk(input string n, input logic [15:0] e, input logic [15:0] s);
      checkCount++;
      if (s !== e)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task rdc(input logic [15:0] m, input logic [15:0] e);
      @(negedge clk) regRead = 1'b1;
      @(negedge clk) regRead = 1'b0;
      chk("readValid", 16'h0001, {15'h0000, readValid});
      chk("readData", e, readData & m);
   endtask
   task wr(input logic [15:0] v);
      @(negedge clk) regWrite = 1'b1;
      writeData = v & 16'h3FFF;
      @(negedge clk) regWrite = 1'b0;
      writeData = 16'h0000;
   endtask
   task print_verdict;
      if (miscompares == 0 && checkCount > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task t_ro;
      roValue = 1'b1;
      wr(16'h0000);
      rdc(16'h0001, 16'h0001);
      roValue = 1'b0;
      wr(16'h0001);
      rdc(16'h0001, 16'h0000);
   endtask
   // reads back to back, so a side effect must land before the next capture
   task t_b2b;
      @(negedge clk) corSet = 1'b1;
      @(negedge clk) corSet = 1'b0;
      wr(16'h0000);
      @(negedge clk) regRead = 1'b1;
      @(negedge clk) chk("cor", 16'h0004, readData & 16'h0006);
      @(negedge clk) regRead = 1'b0;
      chk("sor", 16'h0002, readData & 16'h0006);
   endtask
   task t_w1c;
      @(negedge clk) wacSet = 1'b1;
      w1cSet = 1'b1;
      @(negedge clk) wacSet = 1'b0;
      wr(16'h0010);
      w1cSet = 1'b0;
      rdc(16'h0030, 16'h0010);
      wr(16'h0000);
      rdc(16'h0010, 16'h0010);
      wr(16'h0010);
      rdc(16'h0010, 16'h0000);
   endtask
   task t_latch;
      @(negedge clk) latchLowCond = 1'b1;
      latchHighCond = 1'b1;
      @(negedge clk) latchLowCond = 1'b0;
      latchHighCond = 1'b0;
      rdc(16'h00C0, 16'h0080);
      rdc(16'h00C0, 16'h0040);
   endtask
   task t_status;
      @(negedge clk) statusCond = 1'b1;
      @(negedge clk) statusCond = 1'b0;
      rdc(16'h0400, 16'h0400);
      rdc(16'h0400, 16'h0000);
      statusCond = 1'b1;
      rdc(16'h0400, 16'h0400);
      rdc(16'h0400, 16'h0400);
      statusCond = 1'b0;
      rdc(16'h0400, 16'h0000);
   endtask
   task t_sticky;
      stickyCond = 1'b1;
      wr(16'h0000);
      stickyCond = 1'b0;
      rdc(16'h0800, 16'h0800);
      wr(16'h0000);
      rdc(16'h0800, 16'h0000);
   endtask
   task t_self;
      wr(16'h0100);
      wr(16'h0200);
      rdc(16'h0300, 16'h0100);
      @(negedge clk) selfClearDone = 1'b1;
      selfSetDone = 1'b1;
      @(negedge clk) selfClearDone = 1'b0;
      selfSetDone = 1'b0;
      rdc(16'h0300, 16'h0200);
      chk("selfSetBit", 16'h0001, {15'h0000, selfSetBit});
      chk("selfClearBit", 16'h0000, {15'h0000, selfClearBit});
   endtask
   task t_keep;
      wr(16'h3008);
      chk("woValue", 16'h0001, {15'h0000, woValue});
      @(negedge clk) liteReset = 1'b1;
      @(negedge clk) liteReset = 1'b0;
      chk("keepOnLiteReset", 16'h0001, {15'h0000, keepOnLiteReset});
      chk("keepOnSoftReset", 16'h0000, {15'h0000, keepOnSoftReset});
      chk("woValue", 16'h0000, {15'h0000, woValue});
      wr(16'h3000);
      @(negedge clk) softReset = 1'b1;
      @(negedge clk) softReset = 1'b0;
      chk("keepOnSoftReset", 16'h0001, {15'h0000, keepOnSoftReset});
      chk("keepOnLiteReset", 16'h0000, {15'h0000, keepOnLiteReset});
   endtask
   task t_sysreset;
      wr(16'h3100);
      @(negedge clk) reset_n = 1'b0;
      @(negedge clk) reset_n = 1'b1;
      chk("selfClearBit", 16'h0000, {15'h0000, selfClearBit});
      rdc(16'hFFFF, 16'h0240);
   endtask
   initial
   begin
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      rdc(16'hFFFF, 16'h0240);
      t_ro();
      t_b2b();
      t_w1c();
      t_latch();
      t_status();
      t_sticky();
      t_self();
      t_keep();
      t_sysreset();
      print_verdict();
   end
endmodule // csrbit_policy_bank_tb_top
`default_nettype wire
